// [hdl/owcd_top.sv]
// Option word capture, decode and distribution with AHB-Lite register access
`timescale 1ns/1ns
module owcd_top
    import owcd_pkg::*;
(
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic                  hreadyout,
    output logic                  hresp,
    output logic [31:0]           hrdata,
    input  wire logic [OPT_W-1:0] opt_word0,
    input  wire logic [OPT_W-1:0] opt_word1,
    input  wire logic             prog_mode,
    input  wire logic             noise_pin,
    output logic                  noise_pin_filt,
    output logic                  cfg_loaded,
    output logic                  boot_green,
    output logic                  lvr_enable,
    output logic [1:0]            lvr_level_sel,
    output logic                  reset_pin_ext,
    output logic                  wdog_enable,
    output logic                  noise_filter_en,
    output logic                  noise_width_long,
    output logic                  code_protect,
    output logic [1:0]            rc_freq_sel,
    output logic [4:0]            rc_freq_mhz,
    output logic [5:0]            rc_trim_field,
    output logic [5:0]            osc_mode_onehot,
    output logic                  rc_clk_out_en,
    output logic                  sub_freq_32k,
    output logic [1:0]            cpu_pwr_mode
);
    typedef struct packed {
        logic [OPT_W-1:0] w0_s1;
        logic [OPT_W-1:0] w0_s2;
        logic [OPT_W-1:0] w1_s1;
        logic [OPT_W-1:0] w1_s2;
        logic             prog_s1;
        logic             prog_s2;
        logic             pin_s1;
        logic             pin_s2;
        owcd_ld_t         ld;
        logic [2:0]       ld_cnt;
        logic [OPT_W-1:0] w0;
        logic [OPT_W-1:0] w1;
        logic             loaded;
        logic             boot_green;
        logic             lvr_en;
        logic [1:0]       lvr_sel;
        logic             ext_rst;
        logic             wdog_en;
        logic             nr_en;
        logic             nr_long;
        logic             protect;
        logic [1:0]       rc_sel;
        logic [4:0]       rc_mhz;
        logic [5:0]       trim;
        logic [5:0]       osc_oh;
        logic             clk_out_en;
        logic             sub_32k;
        logic [1:0]       pwr_mode;
        logic             wr_pend;
        logic [5:0]       wr_idx;
        logic [31:0]      rdata;
        logic             readyout;
    } owcd_top_state_t;

    localparam owcd_top_state_t ST_RESET = '{
        w0_s1: W0_DEFAULT, w0_s2: W0_DEFAULT, w1_s1: W1_DEFAULT, w1_s2: W1_DEFAULT,
        prog_s1: 1'b0, prog_s2: 1'b0, pin_s1: 1'b0, pin_s2: 1'b0,
        ld: LD_WAIT, ld_cnt: 3'h0, w0: W0_DEFAULT, w1: W1_DEFAULT, loaded: 1'b0,
        boot_green: 1'b0, lvr_en: 1'b0, lvr_sel: LVR_POR_ONLY, ext_rst: 1'b0,
        wdog_en: 1'b0, nr_en: 1'b1, nr_long: 1'b1, protect: 1'b0, rc_sel: 2'h3,
        rc_mhz: 5'h04, trim: 6'h3F, osc_oh: OH_DEFAULT, clk_out_en: 1'b1,
        sub_32k: 1'b0, pwr_mode: PWR_NORMAL, wr_pend: 1'b0, wr_idx: 6'h00,
        rdata: 32'h0000_0000, readyout: 1'b1
    };

    owcd_top_state_t s_r;
    owcd_top_state_t s_nxt;

    logic       addr_ok;
    logic [5:0] addr_idx;
    logic       filt_bypass;
    logic [5:0] filt_width;

    assign addr_ok  = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign addr_idx = haddr[7:2];

    // Filter is off in low-power modes or when disabled
    assign filt_bypass = (s_r.pwr_mode != PWR_NORMAL) || !s_r.nr_en;
    assign filt_width  = (s_r.osc_oh[OH_LOW] || !s_r.nr_long) ? NR_SHORT : NR_LONG;

    always_comb begin
        s_nxt = s_r;
        s_nxt.w0_s1   = opt_word0;
        s_nxt.w0_s2   = s_r.w0_s1;
        s_nxt.w1_s1   = opt_word1;
        s_nxt.w1_s2   = s_r.w1_s1;
        s_nxt.prog_s1 = prog_mode;
        s_nxt.prog_s2 = s_r.prog_s1;
        s_nxt.pin_s1  = noise_pin;
        s_nxt.pin_s2  = s_r.pin_s1;

        // One capture after release, then frozen until reset
        unique case (s_r.ld)
            LD_WAIT: begin
                s_nxt.ld_cnt = s_r.ld_cnt + 3'h1;
                if (s_r.ld_cnt == LOAD_WAIT_CYCLES - 3'h1) begin
                    s_nxt.ld = LD_CAPT;
                end
            end
            LD_CAPT: begin
                s_nxt.ld         = LD_DONE;
                s_nxt.loaded     = 1'b1;
                s_nxt.w0         = s_r.w0_s2;
                s_nxt.w1         = s_r.w1_s2;
                s_nxt.boot_green = !s_r.w0_s2[W0_BOOT_MODE];
                s_nxt.pwr_mode   = s_r.w0_s2[W0_BOOT_MODE] ? PWR_NORMAL : PWR_GREEN;
                s_nxt.lvr_sel    = s_r.w0_s2[W0_LVR_HI:W0_LVR_LO];
                s_nxt.lvr_en     = s_r.w0_s2[W0_LVR_HI:W0_LVR_LO] != LVR_POR_ONLY;
                s_nxt.ext_rst    = !s_r.w0_s2[W0_RST_PIN];
                s_nxt.wdog_en    = !s_r.w0_s2[W0_WDOG];
                s_nxt.nr_long    = s_r.w0_s2[W0_NR_WIDTH];
                s_nxt.nr_en      = s_r.w0_s2[W0_NR_EN];
                s_nxt.protect    = !(&s_r.w0_s2[W0_PROT_HI:W0_PROT_LO]);
                s_nxt.rc_sel     = s_r.w1_s2[W1_RCSEL_HI:W1_RCSEL_LO];
                s_nxt.rc_mhz     = owcd_rc_mhz(s_r.w1_s2[W1_RCSEL_HI:W1_RCSEL_LO]);
                s_nxt.trim       = s_r.w1_s2[W1_TRIM_HI:W1_TRIM_LO];
                s_nxt.osc_oh     = owcd_osc_onehot(s_r.w1_s2[W1_OSC_HI:W1_OSC_LO]);
                s_nxt.clk_out_en = s_r.w1_s2[W1_CLKOUT];
                s_nxt.sub_32k    = !s_r.w1_s2[W1_SUB_FREQ];
            end
            LD_DONE: begin
                s_nxt.ld = LD_DONE;
            end
            default: begin
                s_nxt.ld = LD_WAIT;
            end
        endcase

        // Data phase of a write
        if (s_r.wr_pend && (s_r.wr_idx == REG_CTRL) && (s_r.ld == LD_DONE)) begin
            s_nxt.pwr_mode = hwdata[1:0];
        end
        if (hready) begin
            s_nxt.wr_pend = addr_ok && hwrite;
            s_nxt.wr_idx  = addr_idx;
        end

        // Read data prepared in the address phase, after any write just done
        if (addr_ok && !hwrite) begin
            s_nxt.rdata = 32'h0000_0000;
            unique case (addr_idx)
                REG_WORD0: begin
                    if (s_r.prog_s2) begin
                        s_nxt.rdata[OPT_W-1:0] = s_r.w0;
                    end
                end
                REG_WORD1: begin
                    if (s_r.prog_s2) begin
                        s_nxt.rdata[OPT_W-1:0] = s_r.w1;
                    end
                end
                REG_CTRL: begin
                    s_nxt.rdata[1:0] = s_nxt.pwr_mode;
                end
                REG_STATUS: begin
                    s_nxt.rdata[ST_LOADED]  = s_r.loaded;
                    s_nxt.rdata[ST_FILT_ON] = !filt_bypass;
                    s_nxt.rdata[ST_WDOG]    = s_r.wdog_en;
                    s_nxt.rdata[ST_PROTECT] = s_r.protect;
                    s_nxt.rdata[ST_GREEN]   = s_r.boot_green;
                end
                default: begin
                    s_nxt.rdata = 32'h0000_0000;
                end
            endcase
        end
        s_nxt.readyout = 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= ST_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    owcd_noise_filter #(
        .CW (6)
    ) u_filt (
        .hclk    (hclk),
        .hresetn (hresetn),
        .din     (s_r.pin_s2),
        .bypass  (filt_bypass),
        .width   (filt_width),
        .dout    (noise_pin_filt)
    );

    assign hreadyout        = s_r.readyout;
    assign hresp            = 1'b0;
    assign hrdata           = s_r.rdata;
    assign cfg_loaded       = s_r.loaded;
    assign boot_green       = s_r.boot_green;
    assign lvr_enable       = s_r.lvr_en;
    assign lvr_level_sel    = s_r.lvr_sel;
    assign reset_pin_ext    = s_r.ext_rst;
    assign wdog_enable      = s_r.wdog_en;
    assign noise_filter_en  = s_r.nr_en;
    assign noise_width_long = s_r.nr_long;
    assign code_protect     = s_r.protect;
    assign rc_freq_sel      = s_r.rc_sel;
    assign rc_freq_mhz      = s_r.rc_mhz;
    assign rc_trim_field    = s_r.trim;
    assign osc_mode_onehot  = s_r.osc_oh;
    assign rc_clk_out_en    = s_r.clk_out_en;
    assign sub_freq_32k     = s_r.sub_32k;
    assign cpu_pwr_mode     = s_r.pwr_mode;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_cfg_hold;
        s_r.loaded && $past(s_r.loaded) |-> $stable(s_r.w0) && $stable(s_r.w1)
            && $stable(s_r.wdog_en) && $stable(s_r.osc_oh);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("settings changed after load");

    property p_load_bound;
        (s_r.ld == LD_WAIT) |-> ##[1:5] s_r.loaded;
    endproperty
    a_load_bound: assert property (p_load_bound) else $error("capture too late");

    property p_boot_mode;
        $rose(s_r.loaded) |-> (boot_green == !s_r.w0[W0_BOOT_MODE])
            && (cpu_pwr_mode == (boot_green ? PWR_GREEN : PWR_NORMAL));
    endproperty
    a_boot_mode: assert property (p_boot_mode) else $error("boot mode wrong");

    property p_lvr;
        s_r.loaded |-> lvr_level_sel == s_r.w0[W0_LVR_HI:W0_LVR_LO]
            && lvr_enable == (s_r.w0[W0_LVR_HI:W0_LVR_LO] != LVR_POR_ONLY);
    endproperty
    a_lvr: assert property (p_lvr) else $error("lvr decode wrong");

    property p_pins_wdog;
        s_r.loaded |-> reset_pin_ext == !s_r.w0[W0_RST_PIN]
            && wdog_enable == !s_r.w0[W0_WDOG];
    endproperty
    a_pins_wdog: assert property (p_pins_wdog) else $error("pin or watchdog wrong");

    property p_width;
        s_r.loaded |-> filt_width == ((osc_mode_onehot[OH_LOW] || !s_r.w0[W0_NR_WIDTH])
            ? NR_SHORT : NR_LONG);
    endproperty
    a_width: assert property (p_width) else $error("filter width wrong");

    property p_bypass;
        (cpu_pwr_mode != PWR_NORMAL) || !noise_filter_en |=> noise_pin_filt == $past(s_r.pin_s2);
    endproperty
    a_bypass: assert property (p_bypass) else $error("filter not bypassed");

    property p_protect;
        s_r.loaded |-> code_protect == (s_r.w0[W0_PROT_HI:W0_PROT_LO] != 3'h7);
    endproperty
    a_protect: assert property (p_protect) else $error("protect decode wrong");

    property p_rc;
        s_r.loaded |-> rc_freq_mhz == owcd_rc_mhz(s_r.w1[W1_RCSEL_HI:W1_RCSEL_LO])
            && rc_trim_field == s_r.w1[W1_TRIM_HI:W1_TRIM_LO];
    endproperty
    a_rc: assert property (p_rc) else $error("rc decode wrong");

    property p_osc_sub;
        s_r.loaded |-> osc_mode_onehot == owcd_osc_onehot(s_r.w1[W1_OSC_HI:W1_OSC_LO])
            && sub_freq_32k == !s_r.w1[W1_SUB_FREQ];
    endproperty
    a_osc_sub: assert property (p_osc_sub) else $error("osc decode wrong");

    property p_hidden;
        addr_ok && !hwrite && (addr_idx <= REG_WORD1) && !s_r.prog_s2 |=> hrdata == 32'h0;
    endproperty
    a_hidden: assert property (p_hidden) else $error("option word visible");

    c_load:  cover property ($rose(s_r.loaded));
    c_green: cover property ($rose(s_r.loaded) && boot_green);
    c_ctrl:  cover property (s_r.wr_pend && s_r.wr_idx == REG_CTRL && s_r.loaded);
    c_filt:  cover property ($changed(noise_pin_filt) && !filt_bypass);
endmodule : owcd_top

// [pkg/owcd_pkg.sv]
// Constants, field layout and decode helpers for the option word decoder
package owcd_pkg;
    localparam int OPT_W = 15;

    // Word 0 fields
    localparam int W0_BOOT_MODE  = 10;
    localparam int W0_LVR_HI     = 8;
    localparam int W0_LVR_LO     = 7;
    localparam int W0_RST_PIN    = 6;
    localparam int W0_WDOG       = 5;
    localparam int W0_NR_WIDTH   = 4;
    localparam int W0_NR_EN      = 3;
    localparam int W0_PROT_HI    = 2;
    localparam int W0_PROT_LO    = 0;

    // Word 1 fields
    localparam int W1_SUB_FREQ   = 13;
    localparam int W1_TRIM_HI    = 12;
    localparam int W1_TRIM_LO    = 7;
    localparam int W1_RCSEL_HI   = 6;
    localparam int W1_RCSEL_LO   = 5;
    localparam int W1_OSC_HI     = 3;
    localparam int W1_OSC_LO     = 1;
    localparam int W1_CLKOUT     = 0;

    localparam logic [OPT_W-1:0] W0_DEFAULT = 15'h25FF;
    localparam logic [OPT_W-1:0] W1_DEFAULT = 15'h3FE7;

    localparam logic [1:0] LVR_POR_ONLY = 2'h3;

    // Oscillator mode codes
    localparam logic [2:0] OSC_HIGH1  = 3'h7;
    localparam logic [2:0] OSC_HIGH2  = 3'h6;
    localparam logic [2:0] OSC_CRYS   = 3'h5;
    localparam logic [2:0] OSC_LOW    = 3'h4;
    localparam logic [2:0] OSC_RC_IO  = 3'h3;
    localparam logic [2:0] OSC_RC_OUT = 3'h2;

    // One-hot oscillator mode flags
    localparam int OH_HIGH1  = 0;
    localparam int OH_HIGH2  = 1;
    localparam int OH_CRYS   = 2;
    localparam int OH_LOW    = 3;
    localparam int OH_RC_IO  = 4;
    localparam int OH_RC_OUT = 5;
    localparam logic [5:0] OH_DEFAULT = 6'h10;

    // Noise filter widths in main clock periods
    localparam logic [5:0] NR_SHORT = 6'h08;
    localparam logic [5:0] NR_LONG  = 6'h20;

    // CPU power mode codes held in the control register
    localparam logic [1:0] PWR_NORMAL = 2'h0;
    localparam logic [1:0] PWR_GREEN  = 2'h1;
    localparam logic [1:0] PWR_IDLE   = 2'h2;
    localparam logic [1:0] PWR_SLEEP  = 2'h3;

    // Register word indices (byte address is four times the index)
    localparam logic [5:0] REG_WORD0  = 6'h00;
    localparam logic [5:0] REG_WORD1  = 6'h01;
    localparam logic [5:0] REG_CTRL   = 6'h02;
    localparam logic [5:0] REG_STATUS = 6'h03;

    // Status bit positions
    localparam int ST_LOADED  = 0;
    localparam int ST_FILT_ON = 1;
    localparam int ST_WDOG    = 2;
    localparam int ST_PROTECT = 3;
    localparam int ST_GREEN   = 4;

    // Settle time after reset release before the capture
    localparam logic [2:0] LOAD_WAIT_CYCLES = 3'h4;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [2:0] {
        LD_WAIT = 3'b001,
        LD_CAPT = 3'b010,
        LD_DONE = 3'b100
    } owcd_ld_t;

    function automatic logic [4:0] owcd_rc_mhz(input logic [1:0] sel);
        unique case (sel)
            2'h0:    owcd_rc_mhz = 5'h01;
            2'h1:    owcd_rc_mhz = 5'h08;
            2'h2:    owcd_rc_mhz = 5'h10;
            default: owcd_rc_mhz = 5'h04;
        endcase
    endfunction : owcd_rc_mhz

    function automatic logic [5:0] owcd_osc_onehot(input logic [2:0] code);
        owcd_osc_onehot = 6'h00;
        unique case (code)
            OSC_HIGH1:  owcd_osc_onehot[OH_HIGH1]  = 1'b1;
            OSC_HIGH2:  owcd_osc_onehot[OH_HIGH2]  = 1'b1;
            OSC_CRYS:   owcd_osc_onehot[OH_CRYS]   = 1'b1;
            OSC_LOW:    owcd_osc_onehot[OH_LOW]    = 1'b1;
            OSC_RC_IO:  owcd_osc_onehot[OH_RC_IO]  = 1'b1;
            OSC_RC_OUT: owcd_osc_onehot[OH_RC_OUT] = 1'b1;
            default:    owcd_osc_onehot = 6'h00;
        endcase
    endfunction : owcd_osc_onehot
endpackage : owcd_pkg

// [hdl/owcd_noise_filter.sv]
// Pulse-width noise rejection filter for one synchronised input
`timescale 1ns/1ns
module owcd_noise_filter
    import owcd_pkg::*;
#(
    parameter int CW = 6
) (
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          din,
    input  wire logic          bypass,
    input  wire logic [CW-1:0] width,
    output logic               dout
);
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          out;
    } owcd_filt_state_t;

    owcd_filt_state_t s_r;
    owcd_filt_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (bypass) begin
            s_nxt.out = din;
            s_nxt.cnt = '0;
        end else if (din == s_r.out) begin
            s_nxt.cnt = '0;
        end else if (s_r.cnt >= width - CW'(1)) begin
            // Level held for the full width counts as signal
            s_nxt.out = din;
            s_nxt.cnt = '0;
        end else begin
            s_nxt.cnt = s_r.cnt + CW'(1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign dout = s_r.out;
endmodule : owcd_noise_filter

// [sim/option_word_config_decode_test.sv]
// Self-checking testbench for the option word decoder
`timescale 1ns/1ns
module option_word_config_decode_test
    import owcd_pkg::*;
();
    logic             hclk;
    logic             hresetn;
    logic             hsel;
    logic [31:0]      haddr;
    logic [1:0]       htrans;
    logic             hwrite;
    logic [2:0]       hsize;
    logic [31:0]      hwdata;
    wire logic        hready;
    logic             hreadyout;
    logic             hresp;
    logic [31:0]      hrdata;
    logic [OPT_W-1:0] opt_word0;
    logic [OPT_W-1:0] opt_word1;
    logic             prog_mode;
    logic             noise_pin;
    logic             noise_pin_filt;
    logic             cfg_loaded;
    logic             boot_green;
    logic             lvr_enable;
    logic [1:0]       lvr_level_sel;
    logic             reset_pin_ext;
    logic             wdog_enable;
    logic             noise_filter_en;
    logic             noise_width_long;
    logic             code_protect;
    logic [1:0]       rc_freq_sel;
    logic [4:0]       rc_freq_mhz;
    logic [5:0]       rc_trim_field;
    logic [5:0]       osc_mode_onehot;
    logic             rc_clk_out_en;
    logic             sub_freq_32k;
    logic [1:0]       cpu_pwr_mode;
    int               error_cnt;
    int               n_compared;
    int               cyc_cnt;
    logic [31:0]      rd;
    logic [14:0]      tw0 [6];
    logic [14:0]      tw1 [6];

    assign hready = hreadyout;

    owcd_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .opt_word0(opt_word0),
        .opt_word1(opt_word1), .prog_mode(prog_mode), .noise_pin(noise_pin),
        .noise_pin_filt(noise_pin_filt), .cfg_loaded(cfg_loaded), .boot_green(boot_green),
        .lvr_enable(lvr_enable), .lvr_level_sel(lvr_level_sel),
        .reset_pin_ext(reset_pin_ext), .wdog_enable(wdog_enable),
        .noise_filter_en(noise_filter_en), .noise_width_long(noise_width_long),
        .code_protect(code_protect), .rc_freq_sel(rc_freq_sel), .rc_freq_mhz(rc_freq_mhz),
        .rc_trim_field(rc_trim_field), .osc_mode_onehot(osc_mode_onehot),
        .rc_clk_out_en(rc_clk_out_en), .sub_freq_32k(sub_freq_32k),
        .cpu_pwr_mode(cpu_pwr_mode));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict

    // Hang guard
    always @(posedge hclk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 30000) begin
            error_cnt++;
            give_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wait_ready;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            @(posedge hclk);
        end
    endtask : wait_ready

    task automatic ahb_xfer(input logic [31:0] a, input logic wr, input logic [31:0] d,
                            output logic [31:0] q);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask : ahb_xfer

    task automatic do_reset(input logic [14:0] w0, input logic [14:0] w1);
        @(posedge hclk);
        hresetn   <= 1'b0;
        opt_word0 <= w0;
        opt_word1 <= w1;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (8) @(posedge hclk);
        #1;
    endtask : do_reset

    function automatic logic [5:0] exp_osc(input logic [2:0] c);
        case (c)
            3'h7:    return 6'h01;
            3'h6:    return 6'h02;
            3'h5:    return 6'h04;
            3'h4:    return 6'h08;
            3'h3:    return 6'h10;
            3'h2:    return 6'h20;
            default: return 6'h00;
        endcase
    endfunction : exp_osc

    task automatic check_cfg(input logic [14:0] w0, input logic [14:0] w1);
        logic [4:0] mhz;
        logic       prot;
        mhz  = (w1[6:5] == 2'h0) ? 5'h01 : (w1[6:5] == 2'h1) ? 5'h08 :
               (w1[6:5] == 2'h2) ? 5'h10 : 5'h04;
        prot = ~&w0[2:0];
        check(32'(cfg_loaded), 32'h1);
        check(32'(boot_green), 32'(!w0[10]));
        check(32'(cpu_pwr_mode), w0[10] ? 32'h0 : 32'h1);
        check(32'(lvr_level_sel), 32'(w0[8:7]));
        check(32'(lvr_enable), 32'(w0[8:7] != 2'h3));
        check(32'(reset_pin_ext), 32'(!w0[6]));
        check(32'(wdog_enable), 32'(!w0[5]));
        check(32'(noise_width_long), 32'(w0[4]));
        check(32'(noise_filter_en), 32'(w0[3]));
        check(32'(code_protect), 32'(prot));
        check(32'(rc_freq_sel), 32'(w1[6:5]));
        check(32'(rc_freq_mhz), 32'(mhz));
        check(32'(rc_trim_field), 32'(w1[12:7]));
        check(32'(osc_mode_onehot), 32'(exp_osc(w1[3:1])));
        check(32'(rc_clk_out_en), 32'(w1[0]));
        check(32'(sub_freq_32k), 32'(!w1[13]));
        ahb_xfer(32'({REG_STATUS, 2'h0}), 1'b0, 32'h0, rd);
        check(rd & 32'hFFFFFFFD, {27'h0, ~w0[10], prot, ~w0[5], 2'h1});
        ahb_xfer(32'({REG_WORD0, 2'h0}), 1'b0, 32'h0, rd);
        check(rd, 32'h0);
        check(32'({hreadyout, hresp}), 32'h2);
    endtask : check_cfg

    task automatic drive_pin(input logic v, input int cyc, input logic exp);
        @(posedge hclk);
        noise_pin <= v;
        repeat (cyc) @(posedge hclk);
        #1;
        check(32'(noise_pin_filt), 32'(exp));
    endtask : drive_pin

    task automatic decode_table;
        for (int i = 0; i < 6; i++) begin
            do_reset(tw0[i], tw1[i]);
            check_cfg(tw0[i], tw1[i]);
        end
    endtask : decode_table

    task automatic hold_and_access;
        do_reset(15'h2000, 15'h150E);
        @(posedge hclk);
        opt_word0 <= 15'h25FF;
        opt_word1 <= 15'h3FE7;
        repeat (10) @(posedge hclk);
        check_cfg(15'h2000, 15'h150E);
        prog_mode <= 1'b1;
        repeat (3) @(posedge hclk);
        ahb_xfer(32'({REG_WORD1, 2'h0}), 1'b0, 32'h0, rd);
        check(rd, 32'h150E);
        ahb_xfer(32'({REG_WORD0, 2'h0}), 1'b1, 32'h1234, rd);
        ahb_xfer(32'({REG_WORD0, 2'h0}), 1'b0, 32'h0, rd);
        check(rd, 32'h2000);
        ahb_xfer(32'h10, 1'b0, 32'h0, rd);
        check(rd, 32'h0);
        prog_mode <= 1'b0;
    endtask : hold_and_access

    task automatic filt_run(input logic [14:0] w0, input logic [14:0] w1, input int w);
        do_reset(w0, w1);
        if (w == 0) begin
            drive_pin(1'b1, 4, 1'b1);
            drive_pin(1'b0, 4, 1'b0);
        end else begin
            drive_pin(1'b1, w - 3, 1'b0);
            drive_pin(1'b0, w + 6, 1'b0);
            drive_pin(1'b1, w + 1, 1'b0);
            drive_pin(1'b1, 4, 1'b1);
            drive_pin(1'b0, w + 1, 1'b1);
            drive_pin(1'b0, 4, 1'b0);
        end
    endtask : filt_run

    task automatic low_power_bypass;
        do_reset(15'h25FF, 15'h3FE7);
        for (int m = 1; m < 4; m++) begin
            ahb_xfer(32'({REG_CTRL, 2'h0}), 1'b1, 32'(m), rd);
            ahb_xfer(32'({REG_CTRL, 2'h0}), 1'b0, 32'h0, rd);
            check(rd, 32'(m));
            check(32'(cpu_pwr_mode), 32'(m));
            drive_pin(1'b1, 4, 1'b1);
            drive_pin(1'b0, 4, 1'b0);
        end
        ahb_xfer(32'({REG_CTRL, 2'h0}), 1'b1, 32'(PWR_NORMAL), rd);
        drive_pin(1'b1, 10, 1'b0);
        drive_pin(1'b0, 40, 1'b0);
    endtask : low_power_bypass

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        opt_word0 = W0_DEFAULT;
        opt_word1 = W1_DEFAULT;
        prog_mode = 1'b0;
        noise_pin = 1'b0;
        error_cnt = 0;
        n_compared = 0;
        cyc_cnt = 0;
        tw0 = '{15'h25FF, 15'h2000, 15'h20FF, 15'h217B, 15'h25FF, 15'h25FF};
        tw1 = '{15'h3FE7, 15'h150E, 15'h20AD, 15'h1FCA, 15'h3FE8, 15'h3FE5};
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        decode_table();
        hold_and_access();
        filt_run(15'h25FF, 15'h3FE7, 32);
        filt_run(15'h25EF, 15'h3FE7, 8);
        filt_run(15'h25FF, 15'h3FE8, 8);
        filt_run(15'h25F7, 15'h3FE7, 0);
        low_power_bypass();
        give_verdict();
    end
endmodule : option_word_config_decode_test
